//--- rtl/alm_layer4_match.sv
`timescale 1ns/100ps
module alm_layer4_match import alm_pkg::*; #(
  parameter int NPORT = ALM_NPORT,
  parameter int PIW   = 2
) (
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  // register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_wdata,
  output logic      [7:0]      reg_rdata_r,
  output logic                 reg_rvalid_r,
  // packet fields
  input  wire logic            pkt_valid,
  input  wire logic [PIW-1:0]  pkt_port_idx,
  input  wire logic [15:0]     pkt_l4_value,
  input  wire logic [7:0]      pkt_proto,
  input  wire logic [7:0]      pkt_tcp_flags,
  input  wire logic [15:0]     bound_max,
  input  wire logic [7:0]      bound_min_hi,
  // match results
  output logic                 match_valid_r,
  output logic                 port_match_r,
  output logic                 proto_match_r,
  output logic                 flag_match_r
);
  localparam int DEPTH = NPORT * ALM_NSLOT;
  localparam int AW    = $clog2(DEPTH);

  // ==========================================================
  // decode helpers
  function automatic logic [3:0] slot_of(input logic [7:0] ofs);
    case (ofs)
      ALM_OFS_MIN_LO: slot_of = {1'b1, ALM_SLOT_MIN_LO};
      ALM_OFS_CTRL:   slot_of = {1'b1, ALM_SLOT_CTRL};
      ALM_OFS_PROTO:  slot_of = {1'b1, ALM_SLOT_PROTO};
      ALM_OFS_TCP_FLAG_MASK:   slot_of = {1'b1, ALM_SLOT_TCP_FLAG_MASK};
      ALM_OFS_FLAG:   slot_of = {1'b1, ALM_SLOT_FLAG};
      default:        slot_of = 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] byte_at(input logic [DEPTH*8-1:0] q,
                                         input int                 idx,
                                         input logic [2:0]         slot);
    byte_at = q[(idx * ALM_NSLOT + int'(slot)) * 8 +: 8];
  endfunction

  // ==========================================================
  // select and offset registers
  logic [7:0]          tbl_sel_r;
  logic [7:0]          tbl_sel_nxt;
  logic [7:0]          ofs_r;
  logic [7:0]          ofs_nxt;
  logic [3:0]          port_num;
  logic [3:0]          slot_hit;
  logic                win_ok;
  logic [AW-1:0]       bank_addr;
  logic                bank_wr;
  logic [7:0]          bank_wdata;
  logic [7:0]          bank_rdata;
  logic [DEPTH*8-1:0]  bank_q;
  logic [7:0]          win_byte;

  always_comb begin
    tbl_sel_nxt = tbl_sel_r;
    ofs_nxt     = ofs_r;
    if (reg_wr && reg_addr == ALM_TBL_SEL_ADDR) begin
      tbl_sel_nxt = reg_wdata;
    end
    if (reg_wr && reg_addr == ALM_OFS_ADDR) begin
      ofs_nxt = reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    tbl_sel_r <= !rst_n ? ALM_TBL_SEL_RST : tbl_sel_nxt;
    ofs_r     <= !rst_n ? ALM_OFS_RST : ofs_nxt;
  end

  // ==========================================================
  // data window decode
  // a wrong table code or port leaves the window dead: reads give zero
  always_comb begin
    port_num  = tbl_sel_r[ALM_PORT_HI:ALM_PORT_LO];
    slot_hit  = slot_of(ofs_r);
    win_ok    = (tbl_sel_r[ALM_TBL_HI:ALM_TBL_LO] == ALM_TBL_ACL)
                && (port_num >= ALM_PORT_MIN)
                && (port_num <= 4'(NPORT))
                && slot_hit[3];
    bank_addr = AW'((int'(port_num) - 1) * ALM_NSLOT + int'(slot_hit[2:0]));
    if (!win_ok) begin
      bank_addr = '0;
    end
    win_byte   = win_ok ? bank_q[int'(bank_addr) * 8 +: 8] : ALM_RD_ZERO;
    bank_wr    = reg_wr && (reg_addr == ALM_DATA_ADDR) && win_ok;
    bank_wdata = reg_wdata;
    if (slot_hit[2:0] == ALM_SLOT_CTRL) begin
      bank_wdata = reg_wdata & ALM_CTRL_WR_MASK;
    end
  end

  alm_byte_bank #(
    .NPORT (NPORT),
    .NSLOT (ALM_NSLOT)
  ) u_bank (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (bank_wr),
    .wr_addr (bank_addr),
    .wr_data (bank_wdata),
    .rd_addr (bank_addr),
    .rd_data (bank_rdata),
    .all_q   (bank_q)
  );

  // ==========================================================
  // read pipeline, two cycles so window data come from the bank register
  logic       rd_p1_r;
  logic       rd_p1_nxt;
  logic       rd_win_r;
  logic       rd_win_nxt;
  logic [7:0] rd_imm_r;
  logic [7:0] rd_imm_nxt;
  logic [7:0] rdata_nxt;

  always_comb begin
    rd_p1_nxt  = reg_rd;
    rd_win_nxt = reg_rd && (reg_addr == ALM_DATA_ADDR) && win_ok;
    case (reg_addr)
      ALM_TBL_SEL_ADDR: rd_imm_nxt = tbl_sel_r;
      ALM_OFS_ADDR:     rd_imm_nxt = ofs_r;
      default:          rd_imm_nxt = ALM_RD_ZERO;
    endcase
    // read data hold between answers, so a late look still sees the last byte
    rdata_nxt = reg_rdata_r;
    if (rd_p1_r) begin
      rdata_nxt = rd_win_r ? bank_rdata : rd_imm_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_p1_r      <= !rst_n ? 1'b0 : rd_p1_nxt;
    rd_win_r     <= !rst_n ? 1'b0 : rd_win_nxt;
    rd_imm_r     <= !rst_n ? ALM_RD_ZERO : rd_imm_nxt;
    reg_rvalid_r <= !rst_n ? 1'b0 : rd_p1_r;
    reg_rdata_r  <= !rst_n ? ALM_RD_ZERO : rdata_nxt;
  end

  // ==========================================================
  // match evaluation for the packet's port
  logic [7:0]   min_lo;
  logic [7:0]   ctrl_b;
  logic [7:0]   pro_b;
  logic [7:0]   tcp_flag_mask_b;
  logic [7:0]   flag_b;
  logic [15:0]  min_bound;
  logic [7:0]   proto_num;
  alm_pc_mode_e mode;
  logic         port_m_nxt;
  logic         proto_m_nxt;
  logic         flag_m_nxt;

  always_comb begin
    min_lo    = byte_at(bank_q, int'(pkt_port_idx), ALM_SLOT_MIN_LO);
    ctrl_b    = byte_at(bank_q, int'(pkt_port_idx), ALM_SLOT_CTRL);
    pro_b     = byte_at(bank_q, int'(pkt_port_idx), ALM_SLOT_PROTO);
    tcp_flag_mask_b    = byte_at(bank_q, int'(pkt_port_idx), ALM_SLOT_TCP_FLAG_MASK);
    flag_b    = byte_at(bank_q, int'(pkt_port_idx), ALM_SLOT_FLAG);
    min_bound = {bound_min_hi, min_lo};
    mode      = alm_pc_mode_e'(ctrl_b[ALM_MODE_HI:ALM_MODE_LO]);
    proto_num = {ctrl_b[ALM_PRO7_BIT], pro_b[ALM_PRO_LOW_HI:0]};
    case (mode)
      ALM_PC_OFF:    port_m_nxt = 1'b1;
      ALM_PC_EITHER: port_m_nxt = (pkt_l4_value == bound_max)
                                  || (pkt_l4_value == min_bound);
      ALM_PC_IN:     port_m_nxt = (pkt_l4_value >= min_bound)
                                  && (pkt_l4_value <= bound_max);
      ALM_PC_OUT:    port_m_nxt = (pkt_l4_value < min_bound)
                                  || (pkt_l4_value > bound_max);
      default:       port_m_nxt = 1'b0;
    endcase
    proto_m_nxt = (pkt_proto == proto_num);
    flag_m_nxt  = ((pkt_tcp_flags ^ flag_b) & tcp_flag_mask_b) == 8'h00;
  end

  // match bits hold until the next packet, match_valid_r is a one-cycle pulse
  always_ff @(posedge sys_clk) begin
    match_valid_r <= !rst_n ? 1'b0 : pkt_valid;
    port_match_r  <= !rst_n ? 1'b0 : (pkt_valid ? port_m_nxt : port_match_r);
    proto_match_r <= !rst_n ? 1'b0 : (pkt_valid ? proto_m_nxt : proto_match_r);
    flag_match_r  <= !rst_n ? 1'b0 : (pkt_valid ? flag_m_nxt : flag_match_r);
  end

  // ==========================================================
  // assertions
  logic win_wr_stay;
  assign win_wr_stay = bank_wr && !(reg_wr && reg_addr inside {ALM_TBL_SEL_ADDR, ALM_OFS_ADDR});

  property p_win_wr;
    @(posedge sys_clk) disable iff (!rst_n)
      win_wr_stay && slot_hit[2:0] != ALM_SLOT_CTRL |=> win_byte == $past(reg_wdata);
  endproperty
  a_win_wr: assert property (p_win_wr) else $error("window write not stored");

  property p_win_rd;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_rd && !reg_wr && reg_addr == ALM_DATA_ADDR |-> ##2 reg_rvalid_r
        && reg_rdata_r == $past(win_byte, 2);
  endproperty
  a_win_rd: assert property (p_win_rd) else $error("window read data wrong");

  property p_min_in;
    @(posedge sys_clk) disable iff (!rst_n)
      pkt_valid && mode == ALM_PC_IN && pkt_l4_value < min_bound |=> !port_match_r;
  endproperty
  a_min_in: assert property (p_min_in) else $error("value below min matched");

  property p_mode_off;
    @(posedge sys_clk) disable iff (!rst_n)
      pkt_valid && mode == ALM_PC_OFF |=> port_match_r && match_valid_r;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("disabled compare not a match");

  property p_mode_either;
    @(posedge sys_clk) disable iff (!rst_n)
      pkt_valid && mode == ALM_PC_EITHER |=> port_match_r == ($past(pkt_l4_value)
        == $past(bound_max) || $past(pkt_l4_value) == $past(min_bound));
  endproperty
  a_mode_either: assert property (p_mode_either) else $error("either-bound match wrong");

  property p_mode_out;
    @(posedge sys_clk) disable iff (!rst_n)
      pkt_valid && mode == ALM_PC_OUT |=> port_match_r == ($past(pkt_l4_value)
        < $past(min_bound) || $past(pkt_l4_value) > $past(bound_max));
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("out-of-range match wrong");

  property p_proto;
    @(posedge sys_clk) disable iff (!rst_n)
      pkt_valid |=> proto_match_r == ($past(pkt_proto) == {$past(ctrl_b[0]), $past(pro_b[6:0])});
  endproperty
  a_proto: assert property (p_proto) else $error("protocol match wrong");

  property p_tcp_flag_mask_rst;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(!rst_n) |-> tcp_flag_mask_b == ALM_RST_TCP_FLAG_MASK && win_byte == ALM_RD_ZERO;
  endproperty
  a_tcp_flag_mask_rst: assert property (p_tcp_flag_mask_rst) else $error("mask not zero after reset");

  property p_flag;
    @(posedge sys_clk) disable iff (!rst_n)
      pkt_valid ##1 !pkt_valid |-> flag_match_r == ((($past(pkt_tcp_flags)
        ^ $past(flag_b)) & $past(tcp_flag_mask_b)) == 8'h00) ##1 $stable(flag_match_r);
  endproperty
  a_flag: assert property (p_flag) else $error("flag match wrong");

  property p_ctrl_rsvd;
    @(posedge sys_clk) disable iff (!rst_n)
      win_wr_stay && slot_hit[2:0] == ALM_SLOT_CTRL |=> win_byte
        == ($past(reg_wdata) & ALM_CTRL_WR_MASK);
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved control bits kept");
endmodule

//--- shared/alm_pkg.sv
// ==========================================================
// layer-4 match field constants
package alm_pkg;
  // ==========================================================
  // direct register addresses
  localparam logic [7:0] ALM_TBL_SEL_ADDR = 8'h6e;
  localparam logic [7:0] ALM_OFS_ADDR     = 8'h6f;
  localparam logic [7:0] ALM_DATA_ADDR    = 8'ha0;
  localparam logic [7:0] ALM_TBL_SEL_RST  = 8'h00;
  localparam logic [7:0] ALM_OFS_RST      = 8'h00;
  localparam logic [7:0] ALM_RD_ZERO      = 8'h00;

  // ==========================================================
  // table select fields
  localparam int         ALM_TBL_HI   = 7;
  localparam int         ALM_TBL_LO   = 5;
  localparam int         ALM_PORT_HI  = 3;
  localparam int         ALM_PORT_LO  = 0;
  localparam logic [2:0] ALM_TBL_ACL  = 3'b010;
  localparam logic [3:0] ALM_PORT_MIN = 4'h1;

  // ==========================================================
  // indirect byte offsets and storage slots
  localparam int         ALM_NPORT      = 4;
  localparam int         ALM_NSLOT      = 5;
  localparam logic [7:0] ALM_OFS_MIN_LO = 8'h05;
  localparam logic [7:0] ALM_OFS_CTRL   = 8'h06;
  localparam logic [7:0] ALM_OFS_PROTO  = 8'h07;
  localparam logic [7:0] ALM_OFS_TCP_FLAG_MASK   = 8'h08;
  localparam logic [7:0] ALM_OFS_FLAG   = 8'h09;
  localparam logic [2:0] ALM_SLOT_MIN_LO = 3'h0;
  localparam logic [2:0] ALM_SLOT_CTRL   = 3'h1;
  localparam logic [2:0] ALM_SLOT_PROTO  = 3'h2;
  localparam logic [2:0] ALM_SLOT_TCP_FLAG_MASK   = 3'h3;
  localparam logic [2:0] ALM_SLOT_FLAG   = 3'h4;

  // ==========================================================
  // control byte fields and reset values
  localparam int         ALM_MODE_HI      = 2;
  localparam int         ALM_MODE_LO      = 1;
  localparam int         ALM_PRO7_BIT     = 0;
  localparam int         ALM_PRO_LOW_HI   = 6;
  localparam logic [7:0] ALM_CTRL_WR_MASK = 8'h07;
  localparam logic [7:0] ALM_RST_MIN_LO   = 8'h00;
  localparam logic [7:0] ALM_RST_CTRL     = 8'h00;
  localparam logic [7:0] ALM_RST_PROTO    = 8'h00;
  localparam logic [7:0] ALM_RST_TCP_FLAG_MASK     = 8'h00;
  localparam logic [7:0] ALM_RST_FLAG     = 8'h00;

  typedef enum logic [1:0] {
    ALM_PC_OFF    = 2'b00,
    ALM_PC_EITHER = 2'b01,
    ALM_PC_IN     = 2'b10,
    ALM_PC_OUT    = 2'b11
  } alm_pc_mode_e;

  function automatic logic [7:0] alm_slot_rst(input int slot);
    case (slot)
      0:       alm_slot_rst = ALM_RST_MIN_LO;
      1:       alm_slot_rst = ALM_RST_CTRL;
      2:       alm_slot_rst = ALM_RST_PROTO;
      3:       alm_slot_rst = ALM_RST_TCP_FLAG_MASK;
      default: alm_slot_rst = ALM_RST_FLAG;
    endcase
  endfunction
endpackage

//--- rtl/alm_byte_bank.sv
`timescale 1ns/100ps
// ==========================================================
// per-port field bytes, registered read, flat view for matching
module alm_byte_bank import alm_pkg::*; #(
  parameter int NPORT = ALM_NPORT,
  parameter int NSLOT = ALM_NSLOT,
  parameter int DEPTH = NPORT * NSLOT,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // write port
  input  wire logic                 wr_en,
  input  wire logic [AW-1:0]        wr_addr,
  input  wire logic [7:0]           wr_data,
  // read port
  input  wire logic [AW-1:0]        rd_addr,
  output logic      [7:0]           rd_data,
  // all contents
  output logic      [DEPTH*8-1:0]   all_q
);
  logic [7:0] mem_r   [DEPTH];
  logic [7:0] mem_nxt [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = (wr_en && (wr_addr == AW'(i))) ? wr_data : mem_r[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_r[i] <= !rst_n ? alm_slot_rst(i % NSLOT) : mem_nxt[i];
    end
    rd_data <= !rst_n ? ALM_RD_ZERO : mem_r[rd_addr];
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_flat
      assign all_q[g*8 +: 8] = mem_r[g];
    end
  endgenerate
endmodule

//--- sim/alm_layer4_match_test.sv
`timescale 1ns/100ps
// ==========================================================
// register window and match result tests
module alm_layer4_match_test import alm_pkg::*;;
  localparam logic [15:0] MINV = 16'h0110;
  localparam logic [15:0] MAXV = 16'h0200;

  logic        sys_clk = 1'b0;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata_r;
  logic        reg_rvalid_r;
  logic        pkt_valid;
  logic [1:0]  pkt_port_idx;
  logic [1:0]  pidx;
  logic [15:0] pkt_l4_value;
  logic [7:0]  pkt_proto;
  logic [7:0]  pkt_tcp_flags;
  logic [15:0] bound_max;
  logic [7:0]  bound_min_hi;
  logic        match_valid_r;
  logic        port_match_r;
  logic        proto_match_r;
  logic        flag_match_r;
  int          errors;
  int          cmp_count;
  int          cycles;
  logic [15:0] vals [5] = '{16'h0110, 16'h0200, 16'h0150, 16'h0050, 16'h0300};

  alm_layer4_match i_dut (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .reg_addr      (reg_addr),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_wdata     (reg_wdata),
    .reg_rdata_r   (reg_rdata_r),
    .reg_rvalid_r  (reg_rvalid_r),
    .pkt_valid     (pkt_valid),
    .pkt_port_idx  (pkt_port_idx),
    .pkt_l4_value  (pkt_l4_value),
    .pkt_proto     (pkt_proto),
    .pkt_tcp_flags (pkt_tcp_flags),
    .bound_max     (bound_max),
    .bound_min_hi  (bound_min_hi),
    .match_valid_r (match_valid_r),
    .port_match_r  (port_match_r),
    .proto_match_r (proto_match_r),
    .flag_match_r  (flag_match_r)
  );

  always #2.5 sys_clk = ~sys_clk;

  // ==========================================================
  // checking and closing
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // hang guard, far above the roughly 630 cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results;
    end
  end

  // ==========================================================
  // register access, at least one idle cycle between strobes
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    // answer is due exactly two edges after the strobe edge, for one cycle
    @(negedge sys_clk);
    check(16'(reg_rvalid_r), 16'h0001);
    check(16'(reg_rdata_r), 16'(exp));
    @(negedge sys_clk);
    check(16'(reg_rvalid_r), 16'h0000);
    check(16'(reg_rdata_r), 16'(exp));
  endtask

  task put(input logic [3:0] p, input logic [7:0] o, input logic [7:0] d);
    wr(ALM_TBL_SEL_ADDR, {ALM_TBL_ACL, 1'b0, p});
    wr(ALM_OFS_ADDR, o);
    wr(ALM_DATA_ADDR, d);
  endtask

  task get(input logic [3:0] p, input logic [7:0] o, input logic [7:0] exp);
    wr(ALM_TBL_SEL_ADDR, {ALM_TBL_ACL, 1'b0, p});
    wr(ALM_OFS_ADDR, o);
    rd(ALM_DATA_ADDR, exp);
  endtask

  // packets arrive on the port index held in pidx
  task pkt(input logic [15:0] v, input logic [7:0] pr, input logic [7:0] fl,
           input logic [2:0] exp);
    @(negedge sys_clk);
    pkt_valid     = 1'b1;
    pkt_port_idx  = pidx;
    pkt_l4_value  = v;
    pkt_proto     = pr;
    pkt_tcp_flags = fl;
    @(negedge sys_clk);
    pkt_valid = 1'b0;
    check(16'(match_valid_r), 16'h0001);
    check(16'({port_match_r, proto_match_r, flag_match_r}), 16'(exp));
  endtask

  function automatic logic pm(input logic [1:0] m, input logic [15:0] v);
    case (m)
      2'b00:   pm = 1'b1;
      2'b01:   pm = (v == MINV) || (v == MAXV);
      2'b10:   pm = (v >= MINV) && (v <= MAXV);
      default: pm = (v < MINV) || (v > MAXV);
    endcase
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    pkt_valid = 1'b0;
    pkt_port_idx = 2'd0;
    pidx = 2'd1;
    pkt_l4_value = 16'h0000;
    pkt_proto = 8'h00;
    pkt_tcp_flags = 8'h00;
    bound_max = MAXV;
    bound_min_hi = MINV[15:8];
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(ALM_TBL_SEL_ADDR, 8'h00);
    rd(ALM_OFS_ADDR, 8'h00);
    for (int p = 1; p <= 4; p++)
      for (int o = 5; o <= 9; o++)
        get(4'(p), 8'(o), 8'h00);
    $display("test reset values done");
    for (int p = 1; p <= 4; p++) begin
      for (int o = 5; o <= 9; o++)
        put(4'(p), 8'(o), {4'(p), 4'(o)} ^ 8'hf8);
    end
    for (int p = 1; p <= 4; p++) begin
      for (int o = 5; o <= 9; o++)
        get(4'(p), 8'(o), o == 6 ? 8'h06 : {4'(p), 4'(o)} ^ 8'hf8);
    end
    // wrong table, port zero and an unmapped address must all stay inert
    wr(ALM_TBL_SEL_ADDR, 8'h21);
    wr(ALM_DATA_ADDR, 8'h00);
    rd(ALM_DATA_ADDR, 8'h00);
    wr(ALM_TBL_SEL_ADDR, 8'h40);
    wr(ALM_DATA_ADDR, 8'hff);
    rd(ALM_DATA_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    get(4'h1, 8'h09, 8'he1);
    put(4'h1, 8'h0a, 8'hff);
    get(4'h1, 8'h0a, 8'h00);
    $display("test register window done");
    put(4'h2, 8'h05, MINV[7:0]);
    put(4'h2, 8'h07, 8'h00);
    put(4'h2, 8'h08, 8'h00);
    for (int m = 0; m < 4; m++) begin
      put(4'h2, 8'h06, {5'b0, 2'(m), 1'b0});
      foreach (vals[i])
        pkt(vals[i], 8'h00, 8'h5a, {pm(2'(m), vals[i]), 2'b11});
    end
    $display("test port modes done");
    put(4'h2, 8'h06, 8'h05);
    put(4'h2, 8'h07, 8'h86);
    pkt(16'h0150, 8'h86, 8'h00, 3'b111);
    pkt(16'h0150, 8'h06, 8'h00, 3'b101);
    put(4'h2, 8'h06, 8'h04);
    pkt(16'h0150, 8'h06, 8'h00, 3'b111);
    $display("test protocol done");
    put(4'h2, 8'h08, 8'h12);
    put(4'h2, 8'h09, 8'h02);
    pkt(16'h0150, 8'h06, 8'hef, 3'b111);
    pkt(16'h0150, 8'h06, 8'h12, 3'b110);
    pkt(16'h0150, 8'h06, 8'h00, 3'b110);
    $display("test flags done");
    // port 1 still holds its window-test bytes: mode 11, min 0x01ed, protocol 0x6f
    pidx = 2'd0;
    pkt(16'h0150, 8'h6f, 8'he1, 3'b111);
    pkt(16'h01f0, 8'h06, 8'h01, 3'b000);
    $display("test port select done");
    results;
  end
endmodule
